// ===== edsc_pkg.sv
/*
  Shared constants, field positions, reset values and types for the
  end-device sleep controller.
  Assumes a single 100 MHz clock and a 32-bit classic Wishbone register bus.
*/
package edsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_MS       = 10;
  localparam int POLL_MS       = 100;
  localparam int UNIT_CYCLES   = (UNIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int POLL_UNITS    = POLL_MS / UNIT_MS;

  ////////////////////////////////////////////////////////////////////////////
  // sleep mode select encodings
  localparam logic [2:0] MODE_PIN     = 3'h1;
  localparam logic [2:0] MODE_CYC     = 3'h4;
  localparam logic [2:0] MODE_CYC_PIN = 3'h5;

  // sleep period limits, in 10 ms units
  localparam logic [11:0] PERIOD_MIN = 12'h020;
  localparam logic [11:0] PERIOD_MAX = 12'hAF0;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_SLEEP    = 8'h04;
  localparam logic [7:0] ADR_HOLD     = 8'h08;
  localparam logic [7:0] ADR_SCAN     = 8'h0C;
  localparam logic [7:0] ADR_CHILD_TO = 8'h10;
  localparam logic [7:0] ADR_STATUS   = 8'h14;

  // field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_FC_BIT    = 3;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RX_BIT    = 2;
  localparam int STAT_HOLD_BIT  = 3;
  localparam int STAT_PKT_BIT   = 4;
  localparam int STAT_EXT_BIT   = 5;
  localparam int STAT_CHILD_LSB = 8;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {SLP_AWAKE, SLP_DRAIN, SLP_ASLEEP} edsc_state_t;
  typedef enum logic [1:0] {POLL_IDLE, POLL_WAIT_ACK, POLL_DATA} edsc_poll_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic        fc_en;
    logic [11:0] sleep_period;
    logic [15:0] wake_hold;
    logic [15:0] scan_mask;
    logic [15:0] child_to;
  } edsc_cfg_t;

  localparam edsc_cfg_t CFG_RST = '{
    mode:         3'h0,
    fc_en:        1'b0,
    sleep_period: 12'h020,
    wake_hold:    16'h0064,
    scan_mask:    16'hFFFF,
    child_to:     16'h0100
  };

endpackage : edsc_pkg

// ===== edsc_tick.sv
/*
  Divider producing a 10 ms unit pulse and a 100 ms poll pulse.
  Assumes one free-running clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module edsc_tick #(
  parameter int UNIT_CYCLES = edsc_pkg::UNIT_CYCLES,
  parameter int POLL_UNITS  = edsc_pkg::POLL_UNITS
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      unit_o,
  output logic      poll_o
);

  logic [31:0] cyc_q, cyc_d;
  logic [7:0]  pu_q,  pu_d;
  logic        unit_q, unit_d, poll_q, poll_d;

  always_comb begin
    cyc_d  = cyc_q + 32'h0000_0001;
    pu_d   = pu_q;
    unit_d = 1'b0;
    poll_d = 1'b0;
    if (cyc_q == 32'(UNIT_CYCLES - 1)) begin
      cyc_d  = 32'h0000_0000;
      unit_d = 1'b1;
      if (pu_q == 8'(POLL_UNITS - 1)) begin // R4
        pu_d   = 8'h00;
        poll_d = 1'b1;
      end else begin
        pu_d = pu_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_q  <= 32'h0000_0000;
      pu_q   <= 8'h00;
      unit_q <= 1'b0;
      poll_q <= 1'b0;
    end else begin
      cyc_q  <= cyc_d;
      pu_q   <= pu_d;
      unit_q <= unit_d;
      poll_q <= poll_d;
    end
  end

  assign unit_o = unit_q;
  assign poll_o = poll_q;

  poll_on_unit_a: assert property (@(posedge clk_i) disable iff (rst_i) poll_o |-> unit_o) // R4
    else $error("poll pulse not aligned to unit pulse");

endmodule : edsc_tick

// ===== edsc_child_table.sv
/*
  Parent-side child table with a per-child poll timeout.
  Assumes unit_i is a one-cycle 10 ms pulse; index inputs are synchronous.
*/
`timescale 1ns/1ps
module edsc_child_table #(
  parameter int N_CHILD = 4,
  parameter int IDX_W   = (N_CHILD > 1) ? $clog2(N_CHILD) : 1
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               unit_i,
  input  wire logic               join_i,
  input  wire logic               poll_i,
  input  wire logic [IDX_W-1:0]   idx_i,
  input  wire logic [15:0]        timeout_i,
  output logic      [N_CHILD-1:0] valid_o,
  output logic                    removed_o
);

  logic [N_CHILD-1:0] val_q, val_d;
  logic [15:0]        cnt_q [N_CHILD];
  logic [15:0]        cnt_d [N_CHILD];
  logic               rem_q, rem_d;

  always_comb begin
    val_d = val_q;
    cnt_d = cnt_q;
    rem_d = 1'b0;
    for (int i = 0; i < N_CHILD; i++) begin
      if (val_q[i] && unit_i) begin
        if (cnt_q[i] >= timeout_i) begin // R1
          val_d[i] = 1'b0;
          rem_d    = 1'b1;
        end else begin
          cnt_d[i] = cnt_q[i] + 16'h0001;
        end
      end
      // a poll in the expiry cycle still keeps the child
      if ((join_i || (poll_i && val_q[i])) && idx_i == IDX_W'(i)) begin // R1
        val_d[i] = 1'b1;
        cnt_d[i] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_q <= '0;
      rem_q <= 1'b0;
      for (int i = 0; i < N_CHILD; i++) begin
        cnt_q[i] <= 16'h0000;
      end
    end else begin
      val_q <= val_d;
      rem_q <= rem_d;
      cnt_q <= cnt_d;
    end
  end

  assign valid_o   = val_q;
  assign removed_o = rem_q;

  poll_keeps_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (poll_i && val_q[idx_i]) |=> val_q[$past(idx_i)]) // R1
    else $error("polling child dropped from table");

  timeout_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (val_q[0] && unit_i && cnt_q[0] >= timeout_i && !join_i && !poll_i) |=> (!val_q[0] && removed_o)) // R1
    else $error("child not removed after poll timeout");

endmodule : edsc_child_table

// ===== edsc_core.sv
/*
  End-device sleep sequencer with parent-side helpers and a Wishbone
  register file. Assumes one 100 MHz clock, synchronous inputs, and a
  radio/MAC around it that reports busy, acks, joined and data events.
*/
// Our own choices: the address map and the Wishbone interface to the registers.
// What this block does
// R1: parent drops a child whose poll request does not arrive within its timeout.
// R2: parent holds a child's remote packet until a route exists, then forwards it.
// R3: sender uses standard retry timeout until it learns destination is an end device.
// R4: while awake the end device polls its parent every 100 ms.
// R5: receiver stays on after a poll until the parent acknowledgment arrives.
// R6: pending data keeps receiver on; otherwise receiver off until next poll.
// R7: awake indicator goes low on entering sleep.
// R8: with flow control on, clear-to-send goes high on entering sleep.
// R9: serial and radio data are ignored while asleep.
// R10: on waking awake indicator high, clear-to-send low if flow control on.
// R11: waking unjoined starts a scan over the configured channel mask.
// R12: sleep mode select value 1 means pin-controlled sleep.
// R13: high sleep request line: finish pending work, then sleep.
// R14: low sleep request line wakes the device in pin sleep.
// R15: sleep mode select values 4 and 5 mean timer-based cyclic sleep.
// R16: mode 5 also wakes on falling sleep request line; mode 4 does not.
// R17: cyclic wake polls once; stay awake on parent data or serial data.
// R18: cyclic data restarts the wake-hold timer; sleep when it expires.
// R19: sleep period counts 10 ms units, limited to 0x20 through 0xAF0.
// R20: sequencer moves awake, draining, asleep; sleep only after drain completes.
// R21: wake-hold time and sleep period are configuration held steady while running.
`timescale 1ns/1ps
module edsc_core #(
  parameter int UNIT_CYCLES = edsc_pkg::UNIT_CYCLES,
  parameter int N_CHILD     = 4,
  parameter int IDX_W       = (N_CHILD > 1) ? $clog2(N_CHILD) : 1
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               sleep_request_line_i,
  input  wire logic               joined_i,
  input  wire logic               busy_i,
  input  wire logic               serial_rx_i,
  input  wire logic               radio_rx_i,
  input  wire logic               ack_rx_i,
  input  wire logic               ack_pending_i,
  output logic                    poll_o,
  output logic                    rx_enable_o,
  output logic                    awake_o,
  output logic                    cts_n_o,
  output logic                    scan_start_o,
  output logic      [15:0]        scan_channel_mask_o,
  input  wire logic               child_join_i,
  input  wire logic               child_poll_i,
  input  wire logic [IDX_W-1:0]   child_idx_i,
  output logic      [N_CHILD-1:0] child_valid_o,
  output logic                    child_removed_o,
  input  wire logic               pkt_in_i,
  input  wire logic               route_ok_i,
  output logic                    pkt_ready_o,
  output logic                    pkt_fwd_o,
  input  wire logic               dest_is_end_i,
  input  wire logic               dest_change_i,
  output logic                    ext_timeout_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] wb_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return r;
  endfunction : wb_merge

  function automatic logic [11:0] period_clamp(input logic [31:0] w);
    logic [11:0] r;
    r = w[11:0];
    if (w > 32'(edsc_pkg::PERIOD_MAX)) r = edsc_pkg::PERIOD_MAX; // R19
    else if (w < 32'(edsc_pkg::PERIOD_MIN)) r = edsc_pkg::PERIOD_MIN; // R19
    return r;
  endfunction : period_clamp

  logic                 tick_unit, tick_poll;
  edsc_pkg::edsc_cfg_t  cfg_q, cfg_d;
  edsc_pkg::edsc_state_t st_q, st_d;
  edsc_pkg::edsc_poll_t  pl_q, pl_d;
  logic                 ack_q, ack_d;
  logic [31:0]          dat_q, dat_d, rd_word, wr_word;
  logic                 first_q, first_d, hold_q, hold_d;
  logic [15:0]          hcnt_q, hcnt_d;
  logic [11:0]          scnt_q, scnt_d;
  logic                 poll_q, poll_d, scan_q, scan_d;
  logic                 awake_q, awake_d, cts_q, cts_d, rqprev_q;
  logic                 pkt_q, pkt_d, fwd_q, fwd_d, ext_q, ext_d;
  logic                 pin_mode, cyc_mode, rq_fall, data_ev, poll_go, wb_req;

  edsc_tick #(
    .UNIT_CYCLES (UNIT_CYCLES),
    .POLL_UNITS  (edsc_pkg::POLL_UNITS)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .unit_o (tick_unit),
    .poll_o (tick_poll)
  );

  edsc_child_table #(
    .N_CHILD (N_CHILD),
    .IDX_W   (IDX_W)
  ) u_child (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .unit_i    (tick_unit),
    .join_i    (child_join_i),
    .poll_i    (child_poll_i),
    .idx_i     (child_idx_i),
    .timeout_i (cfg_q.child_to),
    .valid_o   (child_valid_o),
    .removed_o (child_removed_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wishbone register file

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      edsc_pkg::ADR_CTRL: begin
        rd_word[edsc_pkg::CTRL_MODE_LSB +: 3] = cfg_q.mode;
        rd_word[edsc_pkg::CTRL_FC_BIT]        = cfg_q.fc_en;
      end
      edsc_pkg::ADR_SLEEP:    rd_word[11:0] = cfg_q.sleep_period;
      edsc_pkg::ADR_HOLD:     rd_word[15:0] = cfg_q.wake_hold;
      edsc_pkg::ADR_SCAN:     rd_word[15:0] = cfg_q.scan_mask;
      edsc_pkg::ADR_CHILD_TO: rd_word[15:0] = cfg_q.child_to;
      edsc_pkg::ADR_STATUS: begin
        rd_word[edsc_pkg::STAT_STATE_LSB +: 2] = 2'(st_q);
        rd_word[edsc_pkg::STAT_RX_BIT]         = rx_enable_o;
        rd_word[edsc_pkg::STAT_HOLD_BIT]       = hold_q;
        rd_word[edsc_pkg::STAT_PKT_BIT]        = pkt_q;
        rd_word[edsc_pkg::STAT_EXT_BIT]        = ext_q;
        rd_word[edsc_pkg::STAT_CHILD_LSB +: 8] = 8'(child_valid_o);
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    cfg_d   = cfg_q;
    ack_d   = wb_req;
    dat_d   = dat_q;
    wr_word = wb_merge(rd_word, wb_dat_i, wb_sel_i);
    if (wb_req) begin
      dat_d = rd_word;
      if (wb_we_i) begin
        // software should only retune timing while the link is idle
        case (wb_adr_i)
          edsc_pkg::ADR_CTRL: begin
            cfg_d.mode  = wr_word[edsc_pkg::CTRL_MODE_LSB +: 3];
            cfg_d.fc_en = wr_word[edsc_pkg::CTRL_FC_BIT];
          end
          edsc_pkg::ADR_SLEEP:    cfg_d.sleep_period = period_clamp(wr_word); // R19 R21
          edsc_pkg::ADR_HOLD:     cfg_d.wake_hold = wr_word[15:0]; // R21
          edsc_pkg::ADR_SCAN:     cfg_d.scan_mask = wr_word[15:0];
          edsc_pkg::ADR_CHILD_TO: cfg_d.child_to = wr_word[15:0];
          default:                cfg_d = cfg_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= edsc_pkg::CFG_RST;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = dat_q;
  assign scan_channel_mask_o = cfg_q.scan_mask;

  ////////////////////////////////////////////////////////////////////////////
  // sleep sequencer and poll engine

  assign pin_mode = (cfg_q.mode == edsc_pkg::MODE_PIN); // R12
  assign cyc_mode = (cfg_q.mode == edsc_pkg::MODE_CYC) || (cfg_q.mode == edsc_pkg::MODE_CYC_PIN); // R15
  assign rq_fall  = rqprev_q & ~sleep_request_line_i;
  assign data_ev  = (serial_rx_i | radio_rx_i) & (st_q != edsc_pkg::SLP_ASLEEP); // R9
  // first_q forces one immediate poll after every wake, once joined_i is high
  assign poll_go  = (st_q == edsc_pkg::SLP_AWAKE) && joined_i && (pl_q == edsc_pkg::POLL_IDLE) &&
                    (first_q || (tick_poll && (!cyc_mode || hold_q))); // R4 R17

  always_comb begin
    st_d    = st_q;
    pl_d    = pl_q;
    first_d = first_q;
    hold_d  = hold_q;
    hcnt_d  = hcnt_q;
    scnt_d  = scnt_q;
    poll_d  = 1'b0;
    scan_d  = 1'b0;
    if (hold_q && tick_unit) begin
      if (hcnt_q == 16'h0000) hold_d = 1'b0; // R18
      else hcnt_d = hcnt_q - 16'h0001;
    end
    if (data_ev && cyc_mode) begin // R18
      hold_d = 1'b1;
      hcnt_d = cfg_q.wake_hold;
    end
    case (pl_q)
      edsc_pkg::POLL_IDLE: begin
        if (poll_go) begin
          pl_d    = edsc_pkg::POLL_WAIT_ACK; // R5
          poll_d  = 1'b1;
          first_d = 1'b0;
        end
      end
      edsc_pkg::POLL_WAIT_ACK: begin
        if (ack_rx_i) begin
          if (ack_pending_i) begin
            pl_d = edsc_pkg::POLL_DATA; // R6
            if (cyc_mode) begin // R17
              hold_d = 1'b1;
              hcnt_d = cfg_q.wake_hold;
            end
          end else begin
            pl_d = edsc_pkg::POLL_IDLE; // R6
          end
        end
      end
      edsc_pkg::POLL_DATA: if (radio_rx_i) pl_d = edsc_pkg::POLL_IDLE;
      default: pl_d = edsc_pkg::POLL_IDLE;
    endcase
    case (st_q)
      edsc_pkg::SLP_AWAKE: begin
        if (pin_mode ? sleep_request_line_i : // R13
            (cyc_mode && pl_q == edsc_pkg::POLL_IDLE && !hold_q && (!first_q || !joined_i))) begin // R17
          st_d = edsc_pkg::SLP_DRAIN; // R20
        end
      end
      edsc_pkg::SLP_DRAIN: begin
        if (cyc_mode && hold_q) begin
          st_d = edsc_pkg::SLP_AWAKE;
        end else if (pin_mode && !sleep_request_line_i) begin
          st_d = edsc_pkg::SLP_AWAKE;
        end else if (!busy_i && pl_q == edsc_pkg::POLL_IDLE) begin // R13 R20
          st_d   = edsc_pkg::SLP_ASLEEP;
          scnt_d = cfg_q.sleep_period; // R19
        end
      end
      edsc_pkg::SLP_ASLEEP: begin
        pl_d   = edsc_pkg::POLL_IDLE; // R9
        hold_d = 1'b0;
        if (tick_unit && scnt_q != 12'h000) scnt_d = scnt_q - 12'h001;
        if ((pin_mode && !sleep_request_line_i) || // R14
            (cyc_mode && tick_unit && scnt_q <= 12'h001) || // R15
            (cfg_q.mode == edsc_pkg::MODE_CYC_PIN && rq_fall) || // R16
            (!pin_mode && !cyc_mode)) begin
          st_d    = edsc_pkg::SLP_AWAKE;
          first_d = 1'b1;
          scan_d  = !joined_i; // R11
        end
      end
      default: st_d = edsc_pkg::SLP_AWAKE;
    endcase
  end

  assign awake_d = (st_d != edsc_pkg::SLP_ASLEEP); // R7 R10
  assign cts_d   = cfg_q.fc_en & (st_d == edsc_pkg::SLP_ASLEEP); // R8 R10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q     <= edsc_pkg::SLP_AWAKE;
      pl_q     <= edsc_pkg::POLL_IDLE;
      first_q  <= 1'b1;
      hold_q   <= 1'b0;
      hcnt_q   <= 16'h0000;
      scnt_q   <= 12'h000;
      poll_q   <= 1'b0;
      scan_q   <= 1'b0;
      awake_q  <= 1'b1;
      cts_q    <= 1'b0;
      rqprev_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      pl_q     <= pl_d;
      first_q  <= first_d;
      hold_q   <= hold_d;
      hcnt_q   <= hcnt_d;
      scnt_q   <= scnt_d;
      poll_q   <= poll_d;
      scan_q   <= scan_d;
      awake_q  <= awake_d;
      cts_q    <= cts_d;
      rqprev_q <= sleep_request_line_i;
    end
  end

  assign poll_o       = poll_q;
  assign scan_start_o = scan_q;
  assign awake_o      = awake_q;
  assign cts_n_o      = cts_q;
  assign rx_enable_o  = (pl_q != edsc_pkg::POLL_IDLE); // R5 R6

  ////////////////////////////////////////////////////////////////////////////
  // parent-side route hold and sender timeout choice

  always_comb begin
    pkt_d = pkt_q;
    fwd_d = 1'b0;
    ext_d = ext_q;
    if (pkt_q && route_ok_i) begin // R2
      pkt_d = 1'b0;
      fwd_d = 1'b1;
    end else if (pkt_in_i && !pkt_q) begin
      pkt_d = 1'b1; // R2
    end
    if (dest_change_i) ext_d = 1'b0; // R3
    if (dest_is_end_i) ext_d = 1'b1; // R3
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_q <= 1'b0;
      fwd_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      pkt_q <= pkt_d;
      fwd_q <= fwd_d;
      ext_q <= ext_d;
    end
  end

  assign pkt_ready_o   = ~pkt_q;
  assign pkt_fwd_o     = fwd_q;
  assign ext_timeout_o = ext_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence fwd_once;
    (pkt_fwd_o && !pkt_q) ##1 !pkt_fwd_o;
  endsequence

  sequence wake_edge;
    $fell(st_q == edsc_pkg::SLP_ASLEEP);
  endsequence

  sleep_ind_low_a: assert property ((st_q == edsc_pkg::SLP_ASLEEP) |-> !awake_o) // R7
    else $error("awake indicator high while asleep");
  sleep_cts_a: assert property ((st_q == edsc_pkg::SLP_ASLEEP && $past(cfg_q.fc_en)) |-> cts_n_o) // R8
    else $error("clear-to-send not raised in sleep");
  wake_pins_a: assert property (wake_edge |-> (awake_o && !cts_n_o)) // R10
    else $error("pins wrong after wake");
  wake_scan_a: assert property ((wake_edge ##0 !$past(joined_i)) |-> scan_start_o) // R11
    else $error("no scan after unjoined wake");
  drain_first_a: assert property ((st_q == edsc_pkg::SLP_AWAKE) |=> (st_q != edsc_pkg::SLP_ASLEEP)) // R20
    else $error("slept without draining");
  drain_busy_a: assert property ((st_q == edsc_pkg::SLP_DRAIN && busy_i) |=> (st_q != edsc_pkg::SLP_ASLEEP)) // R13
    else $error("slept while busy");
  ack_wait_rx_a: assert property ((pl_q == edsc_pkg::POLL_WAIT_ACK && !ack_rx_i && st_q != edsc_pkg::SLP_ASLEEP)
    |=> rx_enable_o) // R5
    else $error("receiver off before acknowledgment");
  ack_empty_a: assert property ((pl_q == edsc_pkg::POLL_WAIT_ACK && ack_rx_i && !ack_pending_i) |=> !rx_enable_o) // R6
    else $error("receiver left on without pending data");
  pin_wake_a: assert property ((st_q == edsc_pkg::SLP_ASLEEP && pin_mode && !sleep_request_line_i)
    |=> (st_q == edsc_pkg::SLP_AWAKE && first_q)) // R14
    else $error("pin sleep did not wake on low request");
  mode4_pin_a: assert property ((st_q == edsc_pkg::SLP_ASLEEP && cfg_q.mode == edsc_pkg::MODE_CYC && !tick_unit)
    |=> (st_q == edsc_pkg::SLP_ASLEEP)) // R16
    else $error("mode 4 woke without timer");
  route_fwd_a: assert property ((pkt_q && route_ok_i) |=> fwd_once) // R2
    else $error("held packet not forwarded once");
  sleep_range_a: assert property ((cfg_q.sleep_period >= edsc_pkg::PERIOD_MIN) &&
    (cfg_q.sleep_period <= edsc_pkg::PERIOD_MAX)) // R19
    else $error("sleep period out of range");

endmodule : edsc_core

// ===== edsc_host.sv
/*
  Host model that drives the sleep request line of the sleep controller.
  Assumes the bench sets want_i; the line follows it LAG clock cycles later.
*/
`timescale 1ns/1ps
module edsc_host #(
  parameter int LAG = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic want_i,
  output logic      sleep_request_line_o
);
  logic [LAG-1:0] dly_q;

  // slow host: the line lags the wish, as a real firmware loop would
  always_ff @(posedge clk_i) begin
    if (rst_i)
      dly_q <= '0;
    else
      dly_q <= {dly_q[LAG-2:0], want_i};
  end

  assign sleep_request_line_o = dly_q[LAG-1];
endmodule : edsc_host

// ===== tb.sv
/*
  Self-checking bench for the sleep controller core.
  Assumes 10 clocks per 10 ms unit, so the poll interval is 100 clocks.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic        joined_i = 1'b0;
  logic        busy_i = 1'b0;
  logic        serial_rx_i = 1'b0;
  logic        radio_rx_i = 1'b0;
  logic        ack_rx_i = 1'b0;
  logic        ack_pending_i = 1'b0;
  logic        child_join_i = 1'b0;
  logic        child_poll_i = 1'b0;
  logic [1:0]  child_idx_i = 2'h1;
  logic        pkt_in_i = 1'b0;
  logic        route_ok_i = 1'b0;
  logic        dest_is_end_i = 1'b0;
  logic        dest_change_i = 1'b0;
  logic        want = 1'b0;
  logic        aw_q = 1'b1;
  logic [2:0]  ad_q = 3'h0;
  logic [31:0] wb_dat_o, q;
  logic [15:0] scan_channel_mask_o;
  logic [3:0]  child_valid_o;
  logic        sleep_request_line_i, wb_ack_o, poll_o, rx_enable_o, awake_o, cts_n_o;
  logic        scan_start_o, child_removed_o, pkt_ready_o, pkt_fwd_o, ext_timeout_o;
  int          err_count = 0, checks_done = 0, n_poll = 0, n_scan = 0, n_fwd = 0, n_wake = 0, n, w0, n_rem = 0;

  always #5 clk_i = ~clk_i;

  edsc_core #(.UNIT_CYCLES(10)) dut_u (.*);
  edsc_host #(.LAG(3)) host_u (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
                               .sleep_request_line_o(sleep_request_line_i));

  // parent answers each poll four cycles later
  always @(posedge clk_i) begin
    ad_q <= {ad_q[1:0], poll_o};
    ack_rx_i <= ad_q[2];
    aw_q <= awake_o;
    n_wake += (awake_o && !aw_q);
    n_poll += poll_o;
    n_scan += scan_start_o;
    n_fwd += pkt_fwd_o;
    n_rem += child_removed_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("Error at %0t: bus ack timeout", $time);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({scan_channel_mask_o, awake_o, cts_n_o, pkt_ready_o, ext_timeout_o}, 32'hFFFFA);
    wb(1'b1, 8'h04, 32'h10);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h20);
    wb(1'b1, 8'h04, 32'hFFF);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'hAF0);
    wb(1'b0, 8'h1C, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 8'h00, 32'h9);
    $display("registers done");
    w0 = n_scan;
    busy_i <= 1'b1;
    want <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({awake_o, cts_n_o}, 32'h2);
    wb(1'b0, 8'h14, 32'h0);
    chk(q[1:0], 32'h1);
    busy_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({awake_o, cts_n_o}, 32'h1);
    serial_rx_i <= 1'b1;
    radio_rx_i <= 1'b1;
    @(posedge clk_i);
    serial_rx_i <= 1'b0;
    radio_rx_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(awake_o, 32'h0);
    want <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk({awake_o, cts_n_o}, 32'h2);
    chk(n_scan - w0, 32'h1);
    $display("pin sleep done");
    joined_i <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      ack_pending_i <= k[0];
      n = 0;
      while (poll_o !== 1'b1 && n < 300) begin
        @(posedge clk_i);
        n++;
      end
      chk(n < 300, 32'h1);
      chk(rx_enable_o, 32'h1);
      repeat (8) @(posedge clk_i);
      chk(rx_enable_o, k[0]);
    end
    radio_rx_i <= 1'b1;
    ack_pending_i <= 1'b0;
    @(posedge clk_i);
    radio_rx_i <= 1'b0;
    repeat (150) @(posedge clk_i);
    w0 = n_poll;
    repeat (1000) @(posedge clk_i);
    chk(n_poll - w0, 32'hA);
    $display("polling done");
    wb(1'b1, 8'h10, 32'h3);
    child_join_i <= 1'b1;
    pkt_in_i <= 1'b1;
    dest_is_end_i <= 1'b1;
    @(posedge clk_i);
    child_join_i <= 1'b0;
    pkt_in_i <= 1'b0;
    dest_is_end_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({pkt_ready_o, ext_timeout_o, child_valid_o}, 32'h12);
    route_ok_i <= 1'b1;
    dest_change_i <= 1'b1;
    repeat (5) begin
      repeat (20) @(posedge clk_i);
      child_poll_i <= 1'b1;
      @(posedge clk_i);
      child_poll_i <= 1'b0;
      dest_change_i <= 1'b0;
    end
    chk({pkt_ready_o, ext_timeout_o, child_valid_o, n_fwd[3:0]}, 32'h221);
    repeat (60) @(posedge clk_i);
    chk(child_valid_o, 32'h0);
    chk(n_rem, 32'h1);
    $display("parent side done");
    wb(1'b1, 8'h04, 32'h20);
    want <= 1'b1;
    repeat (30) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h5);
    w0 = n_wake;
    want <= 1'b0;
    repeat (40) @(posedge clk_i);
    chk({n_wake - w0, awake_o}, 32'h2);
    wb(1'b1, 8'h00, 32'h4);
    want <= 1'b1;
    repeat (8) @(posedge clk_i);
    want <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk(n_wake - w0, 32'h1);
    repeat (400) @(posedge clk_i);
    chk(n_wake - w0, 32'h2);
    wb(1'b1, 8'h08, 32'h2);
    wb(1'b1, 8'h00, 32'h5);
    want <= 1'b1;
    repeat (8) @(posedge clk_i);
    want <= 1'b0;
    repeat (6) @(posedge clk_i);
    serial_rx_i <= 1'b1;
    @(posedge clk_i);
    serial_rx_i <= 1'b0;
    repeat (15) @(posedge clk_i);
    chk(awake_o, 32'h1);
    repeat (40) @(posedge clk_i);
    chk(awake_o, 32'h0);
    $display("cyclic sleep done");
    report_and_stop;
  end
endmodule : tb
